/* rtl/kwu_top.sv */
// key-on wakeup: enables, release OR, guard window and warm-up
`timescale 1ns/100ps
`default_nettype none
module kwu_top
  import kwu_pkg::*;
#(
  parameter int NUM_KEYS = 4,
  parameter int WARMUP_CYC = KWU_WARMUP_DEF
)
(
  input  wire logic                clk_sys_i,
  input  wire logic                rst_n_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [7:0]          wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [7:0]          rdata_o,
  input  wire logic [NUM_KEYS-1:0] wake_key_i,
  input  wire logic                dedicated_release_pin_i,
  input  wire logic                release_method_select_i,
  input  wire logic                stop_enter_i,
  output logic                     osc_stopped_o,
  output logic                     stop_release_o,
  output logic                     resume_o
);

  kwu_bus_t            bus;
  kwu_state_t          state_r, state_nxt;
  logic [NUM_KEYS-1:0] en_r, en_nxt;
  logic [NUM_KEYS-1:0] hit;
  logic [15:0]         cnt_r, cnt_nxt;
  logic [7:0]          rdata_r, rdata_nxt;
  logic                rel_pin_r, rel_pin_nxt;
  logic                pin_rel, release_raw;
  logic [15:0]         guard_len_r, guard_len_nxt;
  logic [15:0]         warm_len_r, warm_len_nxt;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ****************************************************************
  // register port
  // ****************************************************************
  // enable register is write only; reads return zero there, while a
  // separate status word shows state and per-key change flags
  always_comb
  begin
    en_nxt    = en_r;
    rdata_nxt = 8'h00;
    if (bus.wr && bus.addr == KWU_ENABLE_OFFS)
      en_nxt = bus.wdata[KWU_EN_LSB +: NUM_KEYS];
    if (bus.rd && bus.addr == KWU_STATUS_OFFS)
      rdata_nxt = {state_r, 4'(hit)};
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      en_r    <= NUM_KEYS'(KWU_EN_RST);
      rdata_r <= 8'h00;
    end
    else
    begin
      en_r    <= en_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata_o = rdata_r;

  // ****************************************************************
  // per-key edge catchers
  // ****************************************************************
  // armed only in stop so normal toggling never looks like a wakeup
  genvar g;
  generate
    for (g = 0; g < NUM_KEYS; g++)
    begin : g_key
      kwu_edge_latch u_latch (
        .pin_i (wake_key_i[g]),
        .arm_i (en_r[g] && state_r == KWU_STOP),
        .clr_i (!rst_n_i),
        .hit_o (hit[g])
      );
    end
  endgenerate

  // ****************************************************************
  // release signal
  // ****************************************************************
  // level mode: high level; edge mode: rising edge of the release pin
  assign pin_rel = release_method_select_i ? dedicated_release_pin_i
                 : (dedicated_release_pin_i && !rel_pin_r);
  assign release_raw = pin_rel || (|hit);
  // gated out during the guard window after entry
  assign stop_release_o = release_raw && state_r == KWU_STOP;

  // ****************************************************************
  // standby sequencer
  // ****************************************************************
  always_comb
  begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    rel_pin_nxt = dedicated_release_pin_i;
    unique case (state_r)
      KWU_RUN:
        if (stop_enter_i)
        begin
          state_nxt = KWU_GUARD;
          cnt_nxt   = 16'(KWU_IGNORE_CYC - 1);
        end
      KWU_GUARD:
        if (cnt_r == 16'h0000)
          state_nxt = KWU_STOP;
        else
          cnt_nxt = cnt_r - 16'h0001;
      KWU_STOP:
        if (release_raw)
        begin
          state_nxt = KWU_WARMUP;
          cnt_nxt   = 16'(WARMUP_CYC - 1);
        end
      KWU_WARMUP:
        if (cnt_r == 16'h0000)
          state_nxt = KWU_RUN;
        else
          cnt_nxt = cnt_r - 16'h0001;
      default:
        state_nxt = KWU_RUN;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= KWU_RUN;
      cnt_r     <= 16'h0000;
      rel_pin_r <= 1'b0;
    end
    else
    begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      rel_pin_r <= rel_pin_nxt;
    end
  end

  assign osc_stopped_o = state_r == KWU_STOP || state_r == KWU_GUARD;
  assign resume_o = state_r == KWU_WARMUP && cnt_r == 16'h0000;

  // ****************************************************************
  // check helpers
  // ****************************************************************
  // run lengths counted apart from the sequencer's own counter, so the
  // guard and warm-up checks do not just echo the logic they judge
  always_comb
  begin
    guard_len_nxt = 16'h0000;
    warm_len_nxt  = 16'h0000;
    if (state_r == KWU_GUARD)
      guard_len_nxt = guard_len_r + 16'h0001;
    if (state_r == KWU_WARMUP)
      warm_len_nxt = warm_len_r + 16'h0001;
  end

  // consecutive cycles spent in guard and in warm-up
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      guard_len_r <= 16'h0000;
      warm_len_r  <= 16'h0000;
    end
    else
    begin
      guard_len_r <= guard_len_nxt;
      warm_len_r  <= warm_len_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_reset_clears: assert property (@(posedge clk_sys_i)
    !rst_n_i |=> en_r == '0) else $error("enables not cleared");
  a_write_enables: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) bus.wr && bus.addr == KWU_ENABLE_OFFS
    |=> en_r == $past(bus.wdata[7:4])) else $error("enable write lost");
  a_guard_ignores: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) state_r == KWU_GUARD |-> !stop_release_o)
    else $error("release seen in guard");
  a_guard_length: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) state_r == KWU_RUN && stop_enter_i
    |=> ##12 state_r == KWU_STOP && guard_len_r == 16'h000c)
    else $error("guard window wrong length");
  a_level_release: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) state_r == KWU_STOP && release_method_select_i
    && dedicated_release_pin_i |-> stop_release_o ##1 state_r == KWU_WARMUP)
    else $error("level release missed");
  a_key_release: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) state_r == KWU_STOP && (|hit)
    |-> stop_release_o) else $error("key event not ored");
  a_key_edge: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) state_r == KWU_STOP && $stable(state_r) && en_r[0]
    && $changed(wake_key_i[0]) |-> stop_release_o)
    else $error("key edge missed");
  a_warmup_time: assert property (@(posedge clk_sys_i)
    disable iff (!rst_n_i) resume_o == (state_r == KWU_WARMUP
    && warm_len_r == 16'(WARMUP_CYC - 1)))
    else $error("warm-up length wrong");

  c_enter_stop: cover property (@(posedge clk_sys_i) state_r == KWU_STOP);
  c_key_wake: cover property (@(posedge clk_sys_i)
    state_r == KWU_STOP && (|hit));
  c_pin_wake: cover property (@(posedge clk_sys_i)
    state_r == KWU_STOP && pin_rel);
  c_resume: cover property (@(posedge clk_sys_i) resume_o);

endmodule : kwu_top
`default_nettype wire

/* rtl/kwu_pkg.sv */
// package: register map, field layout, reset values and timing for key wakeup
package kwu_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] KWU_ENABLE_OFFS = 8'h31; // key_wakeup_enable
  localparam logic [7:0] KWU_STATUS_OFFS = 8'h32; // wakeup status (read)
  localparam int         KWU_EN_LSB      = 4;     // enables sit in bits 7..4
  localparam logic [3:0] KWU_EN_RST      = 4'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int KWU_IGNORE_INSTR = 3;    // instruction cycles after entry
  localparam int KWU_CLK_PER_INSTR = 4;   // clocks per instruction cycle
  localparam int KWU_IGNORE_CYC = KWU_IGNORE_INSTR * KWU_CLK_PER_INSTR;
  localparam int KWU_WARMUP_DEF = 16;     // warm-up clocks, default

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [3:0] {
    KWU_RUN    = 4'h1,
    KWU_GUARD  = 4'h2,
    KWU_STOP   = 4'h4,
    KWU_WARMUP = 4'h8
  } kwu_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } kwu_bus_t;

endpackage : kwu_pkg

/* rtl/kwu_edge_latch.sv */
// one key wakeup input: asynchronous edge catch with asynchronous level clear
`timescale 1ns/100ps
`default_nettype none
module kwu_edge_latch
  import kwu_pkg::*;
(
  input  wire logic pin_i,
  input  wire logic arm_i,
  input  wire logic clr_i,
  output logic      hit_o
);

  logic ref_lvl;

  // ****************************************************************
  // level change detector
  // ****************************************************************
  // the armed reference level is captured while the clock still runs;
  // any difference afterwards is an edge, rising or falling, and needs
  // no clock to be seen, so it can restart a stopped oscillator
  always_latch
  begin
    if (!arm_i || clr_i)
      ref_lvl <= pin_i;
  end

  assign hit_o = arm_i && !clr_i && (pin_i != ref_lvl);

endmodule : kwu_edge_latch
`default_nettype wire

/* tb/kwu_key_model.sv */
// external keys and release pin standing outside the key wakeup block
`timescale 1ns/100ps
`default_nettype none
module kwu_key_model
(
  input  wire logic       clk_sys_i,
  output logic      [3:0] wake_key_o,
  output logic            rel_pin_o
);
  // keys rest at steady levels and move only when told
  initial
  begin
    wake_key_o = 4'h0;
    rel_pin_o  = 1'b0;
  end

  // toggle the selected keys just after an edge
  task automatic flip(input logic [3:0] m);
    @(posedge clk_sys_i);
    wake_key_o <= wake_key_o ^ m;
  endtask : flip

  // release pin level, held until changed again
  task automatic set_rel(input logic v);
    @(posedge clk_sys_i);
    rel_pin_o <= v;
  endtask : set_rel
endmodule : kwu_key_model
`default_nettype wire

/* tb/kwu_top_tb.sv */
// self-checking bench for the key wakeup block
`timescale 1ns/100ps
`default_nettype none
module kwu_top_tb;
  import kwu_pkg::*;
  localparam int W = 4; // short warm-up keeps the run brief
  logic       clk_sys_i = 1'b0;
  logic       rst_n_i = 1'b0;
  kwu_bus_t   bus = '0;
  logic [7:0] rdata_o;
  logic [3:0] keys;
  logic       rel_pin;
  logic       release_method_select = 1'b1;
  logic       stp = 1'b0;
  logic       osc_o;
  logic       rel_o;
  logic       res_o;
  int         fail_count = 0;
  int         samples_checked = 0;
  int         k;
  int         n;
  logic [7:0] en;

  always #2 clk_sys_i = ~clk_sys_i;

  kwu_key_model i_key (.clk_sys_i(clk_sys_i), .wake_key_o(keys),
    .rel_pin_o(rel_pin));
  kwu_top #(.WARMUP_CYC(W)) i_dut (.clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i), .addr_i(bus.addr), .wdata_i(bus.wdata),
    .wr_i(bus.wr), .rd_i(bus.rd), .rdata_o(rdata_o), .wake_key_i(keys),
    .dedicated_release_pin_i(rel_pin), .release_method_select_i(release_method_select),
    .stop_enter_i(stp), .osc_stopped_o(osc_o), .stop_release_o(rel_o),
    .resume_o(res_o));

  // ****
  // tasks
  // ****
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys_i);
    bus.wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys_i);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys_i);
    bus.rd <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rd

  task automatic enter_stop();
    @(posedge clk_sys_i);
    stp <= 1'b1;
    @(posedge clk_sys_i);
    stp <= 1'b0;
  endtask : enter_stop

  // oscillator held stopped, no release seen
  task automatic quiet(input int c);
    repeat (c)
    begin
      #1 chk({7'h0, osc_o}, 8'h01);
      chk({7'h0, rel_o}, 8'h00);
      @(posedge clk_sys_i);
    end
  endtask : quiet

  // bounded wait for the last warm-up cycle
  task automatic wait_res();
    n = 0;
    while (res_o !== 1'b1 && n < 40)
    begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 40)
    begin
      chk(8'h00, 8'h01);
      tally_and_finish();
    end
  endtask : wait_res

  // ****
  // main sequence
  // ****
  initial
  begin
    void'($urandom(14435));
    repeat (16) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rd(KWU_ENABLE_OFFS, 8'h00);
    rd(KWU_STATUS_OFFS, {KWU_RUN, 4'h0});
    rd(8'h55, 8'h00);
    for (k = 0; k < 8; k++)
    begin
      en = 8'($urandom) | (8'h10 << (k % 4));
      release_method_select <= 1'b1;
      wr(KWU_ENABLE_OFFS, en);
      enter_stop();
      i_key.flip(en[7:4]); // moves inside the guard window
      quiet(11);
      i_key.flip(~en[7:4]);
      quiet(3);
      i_key.flip(en[7:4] & (4'h1 << (k % 4)));
      #1 chk({7'h0, rel_o}, 8'h01);
      wait_res();
      chk(8'(n), 8'(W + 1));
      @(posedge clk_sys_i);
      #1 chk({7'h0, osc_o}, 8'h00);
    end
    // a second reset must drop enables written before it
    wr(KWU_ENABLE_OFFS, 8'hf0);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    for (k = 1; k >= 0; k--)
    begin
      release_method_select <= k[0];
      enter_stop();
      quiet(12);
      i_key.flip(4'hf);
      quiet(3);
      i_key.set_rel(1'b1);
      wait_res();
      chk(8'(n >= W + 1 && n <= W + 2), 8'h01);
      i_key.set_rel(1'b0);
    end
    tally_and_finish();
  end
endmodule : kwu_top_tb
`default_nettype wire
